// *** hw/cvs_defs.vh ***
// constants of the converter supervisor and interrupt block
`ifndef CVS_DEFS_VH
`define CVS_DEFS_VH
// clock rate
`define CVS_CLK_MHZ          100
// timing in natural units
`define CVS_LDO_CL_US        90
`define CVS_LDO_OFF_MS       100
`define CVS_I2C_TMO_MS       100
// derived cycle counts
`define CVS_LDO_CL_CYC       (`CVS_LDO_CL_US * `CVS_CLK_MHZ)
`define CVS_LDO_OFF_CYC      (`CVS_LDO_OFF_MS * 1000 * `CVS_CLK_MHZ)
`define CVS_I2C_TMO_CYC      (`CVS_I2C_TMO_MS * 1000 * `CVS_CLK_MHZ)
// audio band floor: 31.25 kHz period in clocks
`define CVS_AUDIO_HZ         31250
`define CVS_AUDIO_PER_CYC    ((`CVS_CLK_MHZ * 1000000) / `CVS_AUDIO_HZ)
// voltages in millivolts, ldo undervoltage level in percent
`define CVS_XOVER_BUCK_MV    16'h03e8
`define CVS_XOVER_BOOST_MV   16'h07d0
`define CVS_LDO_MIN_VIN_MV   16'h0f3c
`define CVS_VIN_OV_MV        16'h5bcc
`define CVS_LDO_BASE_MV      16'h07d0
`define CVS_LDO_STEP_MV      16'h0064
`define CVS_LDO_UV_PCT       8'h58
// temperature in degrees C
`define CVS_TSHUT_C          8'ha0
`define CVS_TSHUT_HYST_C     8'h1e
// interrupt source bit positions
`define CVS_SRC_WDOG         0
`define CVS_SRC_LDO          1
`define CVS_SRC_TSD          2
`define CVS_SRC_FETOC        3
`define CVS_SRC_ADC          4
`define CVS_SRC_IDLE         5
`define CVS_SRC_I2C          6
`define CVS_SRC_OV           7
`define CVS_SRC_UV           8
`define CVS_SRC_LLOFF        9
`define CVS_SRC_HICCUP       10
`define CVS_NSRC             11
// topology codes
`define CVS_TOPO_BUCK        2'h0
`define CVS_TOPO_BB          2'h1
`define CVS_TOPO_BOOST       2'h2
`endif

// *** hw/cvs_timer.v ***
// down-counting timer with load, used for the ldo off time
`timescale 1ns/1ns
`default_nettype none
module cvs_timer #(
  parameter W = 24
) (
  // clock and reset
  input  wire         i_clock,
  input  wire         i_sys_rst,
  // control
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  input  wire         i_run,
  // status
  output wire         o_done,
  output wire         o_busy
);
  reg [W-1:0] cnt;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= {W{1'b0}};
    end else if (i_load) begin
      cnt <= i_count;
    end else if (i_run && cnt != {W{1'b0}}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign o_busy = (cnt != {W{1'b0}});
  assign o_done = (cnt == {{(W-1){1'b0}}, 1'b1}) && i_run && !i_load;
endmodule
`default_nettype wire

// *** hw/cvs_supervisor.v ***
// converter supervisor: topology, pulse skip, idle/run state, ldo, interrupt
//
// Overview of operation
// - buck/buck-boost/boost chosen by crossover thresholds
// - switch drive pattern follows topology
// - pulse skip allowed unless disable bit set
// - audio limit keeps skip rate above 31.25kHz
// - power-up enters idle with default registers
// - enable high moves idle to running
// - ldo on in idle if vin ok, enabled
// - ldo target is 2.0V plus 100mV per code
// - auto ldo source lower rail unless headroom
// - override bit lets select bit pick source
// - ldo fault stops converter, sets flag
// - ldo current limit 90us: off 100ms, retry
// - ldo undervoltage below 88 percent target
// - ldo fault resets state unless ignored
// - i2c transaction over 100ms raises event
// - vin over/under voltage level interrupts
// - per-source mask, self-clearing clear bit
// - watchdog level needs reset and clear
// - ldo fault held until regulating and clear
// - thermal level above 160C, hysteresis release
// - fet overcurrent latch cleared by idle
// - adc, idle, light-load, hiccup are edge events
// - open-drain active-low interrupt line
`timescale 1ns/1ns
`default_nettype none
`include "cvs_defs.vh"
module cvs_supervisor #(
  parameter                     NSRC        = `CVS_NSRC,
  parameter [31:0]              LDO_OFF_CYC = `CVS_LDO_OFF_CYC,
  parameter [31:0]              I2C_TMO_CYC = `CVS_I2C_TMO_CYC,
  parameter [15:0]              XBUCK_MV    = `CVS_XOVER_BUCK_MV,
  parameter [15:0]              XBOOST_MV   = `CVS_XOVER_BOOST_MV
) (
  // clock and reset
  input  wire                   i_clock,
  input  wire                   i_sys_rst,
  // measured quantities, millivolts and degrees C
  input  wire [15:0]            i_vin_mv,
  input  wire [15:0]            i_vout_mv,
  input  wire [15:0]            i_input_sense_pin_mv,
  input  wire [15:0]            i_ldo_out_mv,
  input  wire [7:0]             i_die_temp_c,
  input  wire [15:0]            i_input_undervoltage_threshold,
  // analog status
  input  wire                   i_ldo_cur_limit,
  input  wire                   i_ldo_headroom_low,
  input  wire                   i_light_load,
  input  wire                   i_pwm_pulse,
  // pins and events
  input  wire                   i_enable,
  input  wire                   i_force_idle,
  input  wire                   i_wdog_expired,
  input  wire                   i_fet_oc_trip,
  input  wire                   i_adc_done,
  input  wire                   i_light_load_off_state,
  input  wire                   i_hiccup_enter,
  input  wire                   i_i2c_start,
  input  wire                   i_i2c_stop,
  // configuration bits
  input  wire                   i_pulse_skip_disable,
  input  wire                   i_audio_band_limit_enable,
  input  wire                   i_aux_ldo_disable,
  input  wire                   i_ldo_source_override,
  input  wire                   i_ldo_source_select,
  input  wire                   i_ldo_fault_ignore,
  input  wire [4:0]             i_aux_ldo_code,
  input  wire [NSRC-1:0]        i_irq_mask,
  input  wire                   i_interrupt_clear,
  // converter control
  output reg  [1:0]             o_topology,
  output reg  [3:0]             o_sw_on,
  output reg  [3:0]             o_sw_switching,
  output reg                    o_pulse_skip_operation,
  output reg                    o_audio_pulse,
  output reg                    o_running,
  output reg                    o_idle_standby_state,
  // ldo
  output reg                    o_aux_ldo_en,
  output reg                    o_ldo_from_vin,
  output reg  [15:0]            o_ldo_target_mv,
  output reg                    o_ldo_fault_flag,
  output reg                    o_ldo_uv,
  // i2c watchdog
  output reg                    o_i2c_abort,
  // interrupt
  output reg  [NSRC-1:0]        o_irq_pending,
  output wire                   o_interrupt_clear_rd,
  output wire                   o_interrupt_out_n_o,
  output wire                   o_interrupt_out_n_oe_n
);
  localparam [31:0] LDO_CL_CYC = `CVS_LDO_CL_CYC;
  localparam integer AUD_CYC_I = `CVS_AUDIO_PER_CYC;
  localparam [15:0] AUD_CYC    = AUD_CYC_I[15:0];

  // one-hot states
  localparam [2:0] ST_RST  = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_RUN  = 3'h4;

  function [15:0] sat_sub;
    input [15:0] a;
    input [15:0] b;
    begin
      sat_sub = (a > b) ? (a - b) : 16'h0000;
    end
  endfunction

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  wire        ldo_fault;
  wire        ldo_fault_stop;
  wire        ldo_cl_long;
  wire        ldo_off_busy;
  reg  [31:0] cl_cnt;
  reg         i2c_busy;
  reg  [31:0] i2c_cnt;
  reg  [15:0] skip_cnt;
  reg         tsd_hot;
  reg         fet_oc_latch;
  reg  [NSRC-1:0] lvl;
  reg  [NSRC-1:0] evt;
  wire        enter_idle;

  // topology steps through buck-boost at the two thresholds; each uses the same limit both ways, no hysteresis
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_topology <= `CVS_TOPO_BUCK;
    end else begin
      case (o_topology)
        `CVS_TOPO_BUCK:
          if (sat_sub(i_vin_mv, i_vout_mv) < XBUCK_MV)
            o_topology <= `CVS_TOPO_BB;
        `CVS_TOPO_BB:
          if (sat_sub(i_vout_mv, i_vin_mv) > XBOOST_MV)
            o_topology <= `CVS_TOPO_BOOST;
          else if (sat_sub(i_vin_mv, i_vout_mv) >= XBUCK_MV)
            o_topology <= `CVS_TOPO_BUCK;
        `CVS_TOPO_BOOST:
          if (sat_sub(i_vout_mv, i_vin_mv) <= XBOOST_MV)
            o_topology <= `CVS_TOPO_BB;
        default:
          o_topology <= `CVS_TOPO_BUCK;
      endcase
    end
  end

  // switch pattern, bit0 is switch one; nothing switches unless running
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sw_on        <= 4'h0;
      o_sw_switching <= 4'h0;
    end else if (!o_running) begin
      o_sw_on        <= 4'h0;
      o_sw_switching <= 4'h0;
    end else begin
      case (o_topology)
        `CVS_TOPO_BUCK: begin
          o_sw_on        <= 4'h1;
          o_sw_switching <= 4'hc;
        end
        `CVS_TOPO_BOOST: begin
          o_sw_on        <= 4'h8;
          o_sw_switching <= 4'h3;
        end
        default: begin
          o_sw_on        <= 4'h0;
          o_sw_switching <= 4'hf;
        end
      endcase
    end
  end

  // pulse skip and audio floor
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pulse_skip_operation <= 1'b0;
      o_audio_pulse          <= 1'b0;
      skip_cnt               <= 16'h0000;
    end else begin
      o_pulse_skip_operation <= o_running && i_light_load &&
                                !i_pulse_skip_disable;
      o_audio_pulse <= 1'b0;
      if (!o_pulse_skip_operation || i_pwm_pulse) begin
        skip_cnt <= 16'h0000;
      end else if (i_audio_band_limit_enable) begin
        // force a pulse once the gap reaches one floor period
        if (skip_cnt >= AUD_CYC - 16'h0001) begin
          skip_cnt      <= 16'h0000;
          o_audio_pulse <= 1'b1;
        end else begin
          skip_cnt <= skip_cnt + 16'h0001;
        end
      end
    end
  end

  // ldo control
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ldo_target_mv <= `CVS_LDO_BASE_MV;
      o_ldo_from_vin  <= 1'b1;
      o_ldo_uv        <= 1'b0;
    end else begin
      o_ldo_target_mv <= `CVS_LDO_BASE_MV +
                         `CVS_LDO_STEP_MV * {11'h000, i_aux_ldo_code};
      if (i_ldo_source_override)
        o_ldo_from_vin <= i_ldo_source_select;
      else if (i_vin_mv <= i_vout_mv)
        o_ldo_from_vin <= !i_ldo_headroom_low;
      else
        o_ldo_from_vin <= i_ldo_headroom_low;
      // 100*out < 88*target, widened to avoid overflow
      o_ldo_uv <= o_aux_ldo_en &&
                  ({8'h00, i_ldo_out_mv} * 24'h000064 <
                   {8'h00, o_ldo_target_mv} *
                   {16'h0000, `CVS_LDO_UV_PCT});
    end
  end

  // current-limit dwell
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cl_cnt <= 32'h0;
    end else if (!i_ldo_cur_limit || !o_aux_ldo_en) begin
      cl_cnt <= 32'h0;
    end else if (cl_cnt <= LDO_CL_CYC) begin
      cl_cnt <= cl_cnt + 32'h1;
    end
  end
  assign ldo_cl_long = (cl_cnt > LDO_CL_CYC);

  cvs_timer #(
    .W       (32)
  ) u_ldo_off (
    .i_clock  (i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load   (ldo_cl_long && !ldo_off_busy),
    .i_count  (LDO_OFF_CYC),
    .i_run    (1'b1),
    .o_done   (),
    .o_busy   (ldo_off_busy)
  );

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_aux_ldo_en <= 1'b0;
    end else begin
      // off period then retry; cycle repeats while overload stays
      o_aux_ldo_en <= !state[0] && !i_aux_ldo_disable &&
                      (i_vin_mv > `CVS_LDO_MIN_VIN_MV) &&
                      !ldo_off_busy && !ldo_cl_long;
    end
  end

  assign ldo_fault      = ldo_cl_long || ldo_off_busy || o_ldo_uv;
  assign ldo_fault_stop = ldo_fault && !i_ldo_fault_ignore;

  // flag follows fault; retained until clear once regulating
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ldo_fault_flag <= 1'b0;
    end else if (ldo_fault) begin
      o_ldo_fault_flag <= 1'b1;
    end else if (i_interrupt_clear) begin
      o_ldo_fault_flag <= 1'b0;
    end
  end

  // main state machine
  always @* begin
    next_state = state;
    case (state)
      ST_RST:  next_state = ST_IDLE;
      ST_IDLE: if (i_enable && !ldo_fault_stop && !fet_oc_latch &&
                   !tsd_hot && !i_force_idle)
                 next_state = ST_RUN;
      ST_RUN: begin
        if (ldo_fault_stop)
          next_state = ST_RST;
        else if (!i_enable || i_force_idle)
          next_state = ST_IDLE;
      end
      default: next_state = ST_RST;
    endcase
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_RST;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_running            <= 1'b0;
      o_idle_standby_state <= 1'b0;
    end else begin
      o_running            <= (next_state == ST_RUN) && !tsd_hot &&
                              !fet_oc_latch;
      o_idle_standby_state <= (next_state == ST_IDLE);
    end
  end
  assign enter_idle = (next_state == ST_IDLE) && (state != ST_IDLE);

  // i2c transaction timeout
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      i2c_busy    <= 1'b0;
      i2c_cnt     <= 32'h0;
      o_i2c_abort <= 1'b0;
    end else begin
      o_i2c_abort <= 1'b0;
      if (i_i2c_start) begin
        i2c_busy <= 1'b1;
        i2c_cnt  <= 32'h0;
      end else if (i_i2c_stop) begin
        i2c_busy <= 1'b0;
      end else if (i2c_busy) begin
        if (i2c_cnt >= I2C_TMO_CYC) begin
          i2c_busy    <= 1'b0;
          o_i2c_abort <= 1'b1;
        end else begin
          i2c_cnt <= i2c_cnt + 32'h1;
        end
      end
    end
  end

  // thermal hysteresis and fet overcurrent latch
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tsd_hot      <= 1'b0;
      fet_oc_latch <= 1'b0;
    end else begin
      if (i_die_temp_c > `CVS_TSHUT_C)
        tsd_hot <= 1'b1;
      else if (i_die_temp_c < `CVS_TSHUT_C - `CVS_TSHUT_HYST_C)
        tsd_hot <= 1'b0;
      if (i_fet_oc_trip && o_running)
        fet_oc_latch <= 1'b1;
      else if (state == ST_IDLE)
        fet_oc_latch <= 1'b0;
    end
  end

  // level conditions and edge events
  always @* begin
    lvl = {NSRC{1'b0}};
    evt = {NSRC{1'b0}};
    lvl[`CVS_SRC_WDOG]  = i_wdog_expired;
    lvl[`CVS_SRC_LDO]   = ldo_fault;
    lvl[`CVS_SRC_TSD]   = tsd_hot;
    lvl[`CVS_SRC_FETOC] = fet_oc_latch;
    lvl[`CVS_SRC_OV]    = !state[0] &&
                          (i_vin_mv > `CVS_VIN_OV_MV);
    lvl[`CVS_SRC_UV]    = !state[0] &&
                          (i_input_sense_pin_mv < i_input_undervoltage_threshold);
    evt[`CVS_SRC_ADC]    = i_adc_done;
    evt[`CVS_SRC_IDLE]   = enter_idle;
    evt[`CVS_SRC_I2C]    = o_i2c_abort;
    evt[`CVS_SRC_LLOFF]  = i_light_load_off_state;
    evt[`CVS_SRC_HICCUP] = i_hiccup_enter;
  end

  // pending: set wins over clear; level sources stay while active
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_pending <= {NSRC{1'b0}};
    end else if (i_interrupt_clear) begin
      o_irq_pending <= lvl | evt;
    end else begin
      o_irq_pending <= o_irq_pending | lvl | evt;
    end
  end

  assign o_interrupt_clear_rd   = 1'b0;
  // open drain: enable low pulls the line, value always low
  assign o_interrupt_out_n_o    = 1'b0;
  assign o_interrupt_out_n_oe_n = ~|(o_irq_pending & ~i_irq_mask);
endmodule
`default_nettype wire

// *** tb/cvs_checker.sv ***
// concurrent checks on the converter supervisor ports
`timescale 1ns/1ns
`default_nettype none
module cvs_checker #(
  parameter NSRC = 11
) (
  input wire logic            i_clock,
  input wire logic            i_sys_rst,
  input wire logic [7:0]      i_die_temp_c,
  input wire logic [15:0]     i_vin_mv,
  input wire logic [4:0]      i_aux_ldo_code,
  input wire logic            i_adc_done,
  input wire logic            i_interrupt_clear,
  input wire logic            i_pulse_skip_disable,
  input wire logic            i_ldo_source_override,
  input wire logic            i_ldo_source_select,
  input wire logic [NSRC-1:0] i_irq_mask,
  input wire logic [1:0]      o_topology,
  input wire logic [3:0]      o_sw_on,
  input wire logic [3:0]      o_sw_switching,
  input wire logic            o_running,
  input wire logic            o_idle_standby_state,
  input wire logic            o_pulse_skip_operation,
  input wire logic            o_ldo_from_vin,
  input wire logic [15:0]     o_ldo_target_mv,
  input wire logic [NSRC-1:0] o_irq_pending,
  input wire logic            o_interrupt_out_n_o,
  input wire logic            o_interrupt_out_n_oe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // {on, switching} per topology
  function automatic [7:0] sw_pat(input [1:0] t);
    case (t)
      2'h0: sw_pat = 8'h1c;
      2'h2: sw_pat = 8'h83;
      default: sw_pat = 8'h0f;
    endcase
  endfunction
  sequence s_adc_then_clear;
    i_adc_done ##[1:8] (i_interrupt_clear && !i_adc_done);
  endsequence
  AST_LINE: assert property (!o_interrupt_out_n_o && o_interrupt_out_n_oe_n ==
    !(|(o_irq_pending & ~i_irq_mask))) else $error("irq line level wrong");
  AST_ADC_SET: assert property (i_adc_done |=> o_irq_pending[4])
    else $error("adc event not pending");
  AST_ADC_CLR: assert property (s_adc_then_clear |=> !o_irq_pending[4])
    else $error("adc event not cleared");
  AST_TSD: assert property (i_die_temp_c > 8'ha0 |-> ##2
    o_irq_pending[2]) else $error("thermal not pending");
  AST_OV: assert property ((i_vin_mv > 16'h5bcc && (o_running ||
    o_idle_standby_state)) |=> o_irq_pending[7]) else $error("ov not pending");
  AST_PWM: assert property (i_pulse_skip_disable |-> ##1
    !o_pulse_skip_operation) else $error("skip while disabled");
  AST_LDO_TGT: assert property ((!$past(i_sys_rst) && $stable(i_aux_ldo_code))
    |-> o_ldo_target_mv == 16'h07d0 + 16'h0064 * i_aux_ldo_code)
    else $error("ldo target wrong");
  AST_SRC: assert property (i_ldo_source_override |=>
    o_ldo_from_vin == $past(i_ldo_source_select)) else $error("ldo source");
  AST_TOPO_SW: assert property ((o_running && $past(o_running) &&
    $stable(o_topology)) |-> {o_sw_on, o_sw_switching} == sw_pat(o_topology))
    else $error("switch pattern wrong");
endmodule
bind cvs_supervisor cvs_checker #(.NSRC(NSRC)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_die_temp_c(i_die_temp_c),
  .i_vin_mv(i_vin_mv), .i_aux_ldo_code(i_aux_ldo_code),
  .i_adc_done(i_adc_done), .i_interrupt_clear(i_interrupt_clear),
  .i_pulse_skip_disable(i_pulse_skip_disable),
  .i_ldo_source_override(i_ldo_source_override),
  .i_ldo_source_select(i_ldo_source_select), .i_irq_mask(i_irq_mask),
  .o_topology(o_topology), .o_sw_on(o_sw_on),
  .o_sw_switching(o_sw_switching), .o_running(o_running),
  .o_idle_standby_state(o_idle_standby_state),
  .o_pulse_skip_operation(o_pulse_skip_operation),
  .o_ldo_from_vin(o_ldo_from_vin), .o_ldo_target_mv(o_ldo_target_mv),
  .o_irq_pending(o_irq_pending), .o_interrupt_out_n_o(o_interrupt_out_n_o),
  .o_interrupt_out_n_oe_n(o_interrupt_out_n_oe_n)
);
`default_nettype wire

// *** tb/cvs_host_model.sv ***
// host side: interrupt pull-up and clear-bit writes
`timescale 1ns/1ns
`default_nettype none
module cvs_host_model (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // interrupt pin halves from the device
  input  wire logic i_irq_o,
  input  wire logic i_irq_oe_n,
  // bench asks for one clear write
  input  wire logic i_clear_req,
  // towards device and bench
  output var  logic o_interrupt_clear,
  output wire logic o_interrupt_out_n
);
  // pull-up owns the line once the device lets go
  assign o_interrupt_out_n = i_irq_oe_n ? 1'b1 : i_irq_o;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_interrupt_clear <= 1'b0;
    end else begin
      o_interrupt_clear <= i_clear_req;
    end
  end
endmodule
`default_nettype wire

// *** tb/cvs_supervisor_bench.sv ***
// self-checking bench of the converter supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s expected %0h seen %0h", n, e, g); \
  end end
module cvs_supervisor_bench;
  logic        i_clock = 0, rst = 1, cur_lim = 0, light = 0, en = 0;
  logic        wdog = 0, psd = 0, ldis = 0, ovr = 0, sel = 0, ign = 0;
  logic [15:0] vin = 16'h2ee0, vout = 16'h1388, input_sense_pin = 16'h1388;
  logic [15:0] ldo_out = 16'h1400, uvth = 16'h0dac, tgt;
  logic [7:0]  temp = 8'h32;
  logic [4:0]  code = 0;
  logic [10:0] mask = 0, pend;
  logic [5:0]  evt = 0;
  logic [3:0]  sw_on, sw_sw;
  logic [1:0]  topo;
  logic        pso, run, idle, ldo_en, from_vin, flt, abort, irq_o, oe_n;
  logic        clr, irq_n, aud = 0, fetoc = 0, uv, apulse, clr_rd;
  logic [15:0] vo_tab [4] = '{16'h2af8, 16'h2af9, 16'h36b0, 16'h36b1};
  logic [1:0]  tp_tab [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  int          evb [3] = '{4, 9, 10};
  int          lvb [4] = '{0, 2, 7, 8};
  int          error_cnt = 0, comparisons = 0, cycles = 0, aborts = 0, n;
  int          apulses = 0;
  int unsigned seed = 30;

  cvs_supervisor #(.LDO_OFF_CYC(32'd50), .I2C_TMO_CYC(32'd50)) uut (
    .i_clock(i_clock), .i_sys_rst(rst), .i_vin_mv(vin), .i_vout_mv(vout),
    .i_input_sense_pin_mv(input_sense_pin), .i_ldo_out_mv(ldo_out), .i_die_temp_c(temp),
    .i_input_undervoltage_threshold(uvth), .i_ldo_cur_limit(cur_lim),
    .i_ldo_headroom_low(1'b0), .i_light_load(light), .i_pwm_pulse(1'b0),
    .i_enable(en), .i_force_idle(1'b0), .i_wdog_expired(wdog),
    .i_fet_oc_trip(fetoc), .i_adc_done(evt[0]),
    .i_light_load_off_state(evt[1]), .i_hiccup_enter(evt[2]),
    .i_i2c_start(evt[3]), .i_i2c_stop(evt[4]),
    .i_pulse_skip_disable(psd), .i_audio_band_limit_enable(aud),
    .i_aux_ldo_disable(ldis), .i_ldo_source_override(ovr),
    .i_ldo_source_select(sel), .i_ldo_fault_ignore(ign),
    .i_aux_ldo_code(code), .i_irq_mask(mask), .i_interrupt_clear(clr),
    .o_topology(topo), .o_sw_on(sw_on), .o_sw_switching(sw_sw),
    .o_pulse_skip_operation(pso), .o_audio_pulse(apulse), .o_running(run),
    .o_idle_standby_state(idle), .o_aux_ldo_en(ldo_en),
    .o_ldo_from_vin(from_vin), .o_ldo_target_mv(tgt),
    .o_ldo_fault_flag(flt), .o_ldo_uv(uv), .o_i2c_abort(abort),
    .o_irq_pending(pend), .o_interrupt_clear_rd(clr_rd),
    .o_interrupt_out_n_o(irq_o), .o_interrupt_out_n_oe_n(oe_n));
  cvs_host_model u_host (.i_clock(i_clock), .i_sys_rst(rst),
    .i_irq_o(irq_o), .i_irq_oe_n(oe_n), .i_clear_req(evt[5]),
    .o_interrupt_clear(clr), .o_interrupt_out_n(irq_n));

  always #5 i_clock = ~i_clock;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [15:0] tgt_mv(input [4:0] c);
    return 16'd2000 + 16'd100 * c;
  endfunction
  function automatic [7:0] sw_exp(input [1:0] t);
    return (t == 2'h0) ? 8'h1c : (t == 2'h2) ? 8'h83 : 8'h0f;
  endfunction
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // whole run needs about 16k cycles
  always @(posedge i_clock) begin
    cycles++;
    if (abort) aborts++;
    if (apulse) apulses++;
    if (cycles == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  task automatic pulse(input int k);
    @(posedge i_clock);
    evt[k] <= 1'b1;
    @(posedge i_clock);
    evt[k] <= 1'b0;
  endtask
  task automatic clear();
    pulse(5);
    cyc(3);
  endtask
  task automatic set_lv(input int k, input bit on);
    @(posedge i_clock);
    case (k)
      0: wdog <= on;
      1: temp <= on ? 8'ha1 : 8'h81;
      2: vin <= on ? 16'h5bcd : 16'h2ee0;
      default: input_sense_pin <= on ? 16'h0dab : 16'h1388;
    endcase
  endtask

  initial begin
    cyc(6);
    rst <= 1'b0;
    cyc(4); #1;
    `CHK("idle", 1'b1, idle)
    `CHK("idle entry", 1'b1, pend[5])
    `CHK("irq line", 1'b0, irq_n)
    `CHK("ldo enable", 1'b1, ldo_en)
    clear(); #1;
    `CHK("irq line", 1'b1, irq_n)
    `CHK("clear readback", 1'b0, clr_rd)
    cyc(1);
    ldis <= 1'b1;
    cyc(3); #1;
    `CHK("ldo disabled", 1'b0, ldo_en)
    cyc(1);
    ldis <= 1'b0;
    cyc(1);
    en <= 1'b1;
    cyc(6); #1;
    `CHK("running", 1'b1, run)
    `CHK("auto source", 1'b0, from_vin)
    foreach (vo_tab[i]) begin
      cyc(1);
      vout <= vo_tab[i];
      cyc(4); #1;
      `CHK("topology", tp_tab[i], topo)
      `CHK("switches", sw_exp(tp_tab[i]), {sw_on, sw_sw})
    end
    cyc(1);
    vout <= 16'h1388;
    light <= 1'b1;
    psd <= 1'b1;
    cyc(8); #1;
    `CHK("skip", 1'b0, pso)
    cyc(1);
    psd <= 1'b0;
    cyc(3); #1;
    `CHK("skip", 1'b1, pso)
    // floor period 3200 clocks: two forced pulses in 6500
    cyc(1);
    aud <= 1'b1;
    cyc(6500); #1;
    `CHK("audio pulses", 2, apulses)
    cyc(1);
    aud <= 1'b0;
    for (n = 0; n < 8; n++) begin
      cyc(1);
      code <= (n == 0) ? 5'h1f : 5'(rnd());
      sel <= 1'(rnd());
      ovr <= 1'b1;
      cyc(3); #1;
      `CHK("ldo target", tgt_mv(code), tgt)
      `CHK("ldo source", sel, from_vin)
    end
    foreach (evb[k]) begin
      pulse(k);
      cyc(1); #1;
      `CHK("event", 1'b1, pend[evb[k]])
      clear(); #1;
      `CHK("event", 1'b0, pend[evb[k]])
    end
    cyc(1);
    mask <= 11'h010;
    pulse(0);
    cyc(1); #1;
    `CHK("masked line", 1'b1, irq_n)
    clear();
    mask <= 11'h000;
    pulse(3);
    cyc(40);
    pulse(3);
    cyc(40); #1;
    `CHK("i2c aborts", 0, aborts)
    cyc(20); #1;
    `CHK("i2c aborts", 1, aborts)
    `CHK("i2c event", 1'b1, pend[6])
    clear();
    pulse(3);
    cyc(10);
    pulse(4);
    cyc(60); #1;
    `CHK("i2c aborts", 1, aborts)
    cyc(1);
    cur_lim <= 1'b1;
    for (n = 0; n < 9300 && ldo_en; n++) begin
      @(posedge i_clock);
      #1;
    end
    `CHK("limit dwell", 1'b1, n >= 9000 && n < 9010)
    `CHK("ldo enable", 1'b0, ldo_en)
    `CHK("ldo flag", 1'b1, flt)
    `CHK("running", 1'b0, run)
    cyc(1);
    cur_lim <= 1'b0;
    clear(); #1;
    `CHK("ldo pending", 1'b1, pend[1])
    cyc(60); #1;
    `CHK("ldo retry", 1'b1, ldo_en)
    clear(); #1;
    `CHK("ldo pending", 1'b0, pend[1])
    `CHK("ldo flag", 1'b0, flt)
    foreach (lvb[k]) begin
      set_lv(k, 1'b1);
      clear(); #1;
      `CHK("level held", 1'b1, pend[lvb[k]])
      set_lv(k, 1'b0);
      clear(); #1;
      `CHK("level freed", 1'b0, pend[lvb[k]])
    end
    // 3.3V target: 2904 mV is exactly 88 percent, not below
    cyc(1);
    code <= 5'h0d;
    ign <= 1'b1;
    ldo_out <= 16'h0b58;
    cyc(4); #1;
    `CHK("ldo uv", 1'b0, uv)
    cyc(1);
    ldo_out <= 16'h0b57;
    cyc(4); #1;
    `CHK("ldo uv", 1'b1, uv)
    `CHK("running", 1'b1, run)
    cyc(1);
    ldo_out <= 16'h1400;
    ign <= 1'b0;
    clear();
    fetoc <= 1'b1;
    cyc(1);
    fetoc <= 1'b0;
    cyc(3); #1;
    `CHK("running", 1'b0, run)
    `CHK("fet oc", 1'b1, pend[3])
    clear(); #1;
    `CHK("fet oc held", 1'b1, pend[3])
    cyc(1);
    en <= 1'b0;
    cyc(3);
    clear(); #1;
    `CHK("fet oc freed", 1'b0, pend[3])
    print_verdict();
  end
endmodule
`default_nettype wire
